// ==== rtl/ksm_regs.vh ====
// register map, field positions and slot constants of the key stream field mapper
`ifndef KSM_REGS_VH
`define KSM_REGS_VH
`define KSM_OFS_CTRL 8'h00
`define KSM_OFS_CONFIG 8'h04
`define KSM_OFS_STATUS 8'h08
`define KSM_OFS_LENGTH 8'h0C
`define KSM_OFS_EXTRA 8'h10
`define KSM_CTRL_START 0
`define KSM_CTRL_ABORT 1
`define KSM_CFG_SLOT_LO 0
`define KSM_CFG_PAIR_LO 2
`define KSM_CFG_PROT_LO 4
`define KSM_CFG_TAIL_CT 6
`define KSM_CFG_J_LO 8
`define KSM_CFG_RESET 32'h0000_0001
`define KSM_ST_BUSY 0
`define KSM_ST_DONE 1
`define KSM_ST_SEG 2
`define KSM_ST_IDX_LO 16
`define KSM_SLOT_HALF 2'h0
`define KSM_SLOT_FULL 2'h1
`define KSM_SLOT_DOUBLE 2'h2
`define KSM_PAIR_2_4 2'h0
`define KSM_PAIR_2_8 2'h1
`define KSM_PAIR_4_4 2'h2
`define KSM_PAIR_8_8 2'h3
`define KSM_PROT_NONE 2'h0
`define KSM_PROT_SINGLE 2'h1
`define KSM_PROT_MULTI 2'h2
`define KSM_LEN_HALF_2_4 12'h0C8
`define KSM_LEN_HALF_2_8 12'h118
`define KSM_LEN_HALF_4_4 12'h108
`define KSM_LEN_HALF_8_8 12'h198
`define KSM_LEN_FULL_2_4 12'h2A8
`define KSM_LEN_FULL_2_8 12'h3E8
`define KSM_LEN_FULL_4_4 12'h2E8
`define KSM_LEN_FULL_8_8 12'h468
`define KSM_LEN_DBL_2_4 12'h668
`define KSM_LEN_DBL_2_8 12'h988
`define KSM_LEN_DBL_4_4 12'h6A8
`define KSM_LEN_DBL_8_8 12'hA08
`define KSM_SGL_FULL_2_4 12'h260
`define KSM_SGL_FULL_2_8 12'h3A0
`define KSM_SGL_FULL_4_4 12'h2A0
`define KSM_SGL_FULL_8_8 12'h420
`define KSM_SGL_DBL_2_4 12'h620
`define KSM_SGL_DBL_2_8 12'h940
`define KSM_SGL_DBL_4_4 12'h660
`define KSM_SGL_DBL_8_8 12'h9C0
`define KSM_SGL_HALF_TRIM 12'h048
`define KSM_EXTRA_2 8'h00
`define KSM_EXTRA_4 8'h40
`define KSM_EXTRA_8 8'h80
`define KSM_TAIL_BITS 12'h028
`define KSM_SUB_DATA 7'h40
`define KSM_SUB_LEN 7'h50
`define KSM_SUB_LEN_W 12'h050
`endif

// ==== rtl/ksm_mapper.v ====
// key stream field mapper: bit-serial xor of segment bits onto tail and b-field
`timescale 1ns/1ps
`include "ksm_regs.vh"

module ksm_mapper (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire KS_VALID,
  input wire KS_BIT,
  input wire FLD_BIT,
  output reg OUT_VALID,
  output reg OUT_BIT,
  output reg OUT_ENC,
  output reg [11:0] OUT_INDEX,
  output reg SEG_DONE,
  output reg BUSY
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state;
  reg [31:0] cfg;
  reg [1:0] act_slot;
  reg [1:0] act_pair;
  reg [1:0] act_prot;
  reg act_tail_ct;
  reg [11:0] act_len;
  reg [11:0] act_limit;
  reg [11:0] idx;
  reg [6:0] sub_off;
  reg [11:0] sub_base;
  reg seg;
  reg done;
  reg [11:0] next_len;
  reg [11:0] next_limit;
  reg [7:0] next_extra;
  reg [11:0] j2;
  reg [11:0] j3;
  reg enc;
  reg [11:0] pay_idx;
  reg [31:0] rd;
  reg rd_err;

  wire apb_acc = PSEL & PENABLE & PREADY;
  wire wr = apb_acc & PWRITE;
  wire wr_ctrl = wr & (PADDR == `KSM_OFS_CTRL);
  wire wr_cfg = wr & (PADDR == `KSM_OFS_CONFIG);
  wire wr_stat = wr & (PADDR == `KSM_OFS_STATUS);
  wire start = wr_ctrl & PWDATA[`KSM_CTRL_START] & state[0];
  wire abort = wr_ctrl & PWDATA[`KSM_CTRL_ABORT];
  wire step = state[1] & KS_VALID;
  wire last = step & (idx == act_len - 12'h001);
  wire [1:0] c_slot = cfg[`KSM_CFG_SLOT_LO+1:`KSM_CFG_SLOT_LO];
  wire [1:0] c_pair = cfg[`KSM_CFG_PAIR_LO+1:`KSM_CFG_PAIR_LO];
  wire [1:0] c_prot = cfg[`KSM_CFG_PROT_LO+1:`KSM_CFG_PROT_LO];
  wire [7:0] c_j = cfg[`KSM_CFG_J_LO+7:`KSM_CFG_J_LO];
  wire seg_end = last & seg;
  wire acc_first = PSEL & PENABLE & ~PREADY;
  wire in_tail = idx < `KSM_TAIL_BITS;
  // check bits sit at offsets 64..79 of each subfield
  wire sub_data = sub_off < `KSM_SUB_DATA;
  // a subfield that would run past the b-field payload is not part of this slot
  wire sub_fits = (sub_base + `KSM_SUB_LEN_W) <= act_limit;

  // lengths follow the configuration register; latched at start
  always @* begin
    j2 = {3'h0, c_j, 1'b0};
    j3 = j2 + {4'h0, c_j};
    case (c_slot)
      `KSM_SLOT_HALF: begin
        case (c_pair)
          `KSM_PAIR_2_4: next_len = `KSM_LEN_HALF_2_4 + j2;
          `KSM_PAIR_2_8: next_len = `KSM_LEN_HALF_2_8 + j3;
          `KSM_PAIR_4_4: next_len = `KSM_LEN_HALF_4_4 + j2;
          default: next_len = `KSM_LEN_HALF_8_8 + j3;
        endcase
      end
      `KSM_SLOT_DOUBLE: begin
        case (c_pair)
          `KSM_PAIR_2_4: next_len = `KSM_LEN_DBL_2_4;
          `KSM_PAIR_2_8: next_len = `KSM_LEN_DBL_2_8;
          `KSM_PAIR_4_4: next_len = `KSM_LEN_DBL_4_4;
          default: next_len = `KSM_LEN_DBL_8_8;
        endcase
      end
      default: begin
        case (c_pair)
          `KSM_PAIR_2_4: next_len = `KSM_LEN_FULL_2_4;
          `KSM_PAIR_2_8: next_len = `KSM_LEN_FULL_2_8;
          `KSM_PAIR_4_4: next_len = `KSM_LEN_FULL_4_4;
          default: next_len = `KSM_LEN_FULL_8_8;
        endcase
      end
    endcase
    // payload is everything after the tail bits
    next_limit = next_len - `KSM_TAIL_BITS;
    if (c_prot == `KSM_PROT_SINGLE) begin
      case (c_slot)
        // half slot data limit is a fixed trim below the segment length
        `KSM_SLOT_HALF: begin
          next_limit = next_len - `KSM_SGL_HALF_TRIM;
        end
        `KSM_SLOT_DOUBLE: begin
          case (c_pair)
            `KSM_PAIR_2_4: next_limit = `KSM_SGL_DBL_2_4;
            `KSM_PAIR_2_8: next_limit = `KSM_SGL_DBL_2_8;
            `KSM_PAIR_4_4: next_limit = `KSM_SGL_DBL_4_4;
            default: next_limit = `KSM_SGL_DBL_8_8;
          endcase
        end
        // slot code 3 falls back to the full slot table, as the lengths do
        default: begin
          case (c_pair)
            `KSM_PAIR_2_4: next_limit = `KSM_SGL_FULL_2_4;
            `KSM_PAIR_2_8: next_limit = `KSM_SGL_FULL_2_8;
            `KSM_PAIR_4_4: next_limit = `KSM_SGL_FULL_4_4;
            default: next_limit = `KSM_SGL_FULL_8_8;
          endcase
        end
      endcase
    end
    case (c_pair)
      `KSM_PAIR_4_4: next_extra = `KSM_EXTRA_4;
      `KSM_PAIR_8_8: next_extra = `KSM_EXTRA_8;
      default: next_extra = `KSM_EXTRA_2;
    endcase
  end

  // per index: does this key bit land on a field bit
  always @* begin
    pay_idx = idx - `KSM_TAIL_BITS;
    enc = 1'b0;
    if (in_tail) begin
      enc = act_tail_ct;
    end else begin
      case (act_prot)
        `KSM_PROT_NONE: enc = pay_idx < act_limit;
        // data only: check bits and extra field lie past the limit
        `KSM_PROT_SINGLE: enc = pay_idx < act_limit;
        `KSM_PROT_MULTI: enc = sub_data & sub_fits;
        // code 3 leaves the whole b-field clear
        default: enc = 1'b0;
      endcase
    end
  end

  always @* begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    case (PADDR)
      `KSM_OFS_CTRL: rd = 32'h0000_0000;
      `KSM_OFS_CONFIG: rd = cfg;
      `KSM_OFS_STATUS: begin
        rd[`KSM_ST_BUSY] = state[1];
        rd[`KSM_ST_DONE] = done;
        rd[`KSM_ST_SEG] = seg;
        rd[`KSM_ST_IDX_LO+11:`KSM_ST_IDX_LO] = idx;
      end
      `KSM_OFS_LENGTH: rd = {4'h0, next_limit, 4'h0, next_len};
      `KSM_OFS_EXTRA: rd = {24'h0000_00, next_extra};
      // unmapped offsets answer with an error and read zero
      default: rd_err = 1'b1;
    endcase
  end

  // one wait state on every transfer
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
      cfg <= `KSM_CFG_RESET;
    end else begin
      PREADY <= acc_first;
      // error flag is a one-cycle answer, read data holds until the next transfer
      if (acc_first) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd;
        PSLVERR <= rd_err;
      end else begin
        PSLVERR <= 1'b0;
      end
      // settings cannot move under a running slot
      if (wr_cfg & state[0]) begin
        cfg <= PWDATA & 32'h0000_FF7F;
      end
    end
  end

  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
      act_slot <= 2'h0;
      act_pair <= 2'h0;
      act_prot <= 2'h0;
      act_tail_ct <= 1'b0;
      act_len <= 12'h000;
      act_limit <= 12'h000;
      idx <= 12'h000;
      sub_off <= 7'h00;
      sub_base <= 12'h000;
      seg <= 1'b0;
      done <= 1'b0;
      OUT_VALID <= 1'b0;
      OUT_BIT <= 1'b0;
      OUT_ENC <= 1'b0;
      OUT_INDEX <= 12'h000;
      SEG_DONE <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      OUT_VALID <= step;
      SEG_DONE <= last;
      if (step) begin
        // unmapped bits pass the field bit through untouched
        OUT_BIT <= FLD_BIT ^ (enc & KS_BIT);
        OUT_ENC <= enc;
        OUT_INDEX <= idx;
      end
      // segment end sets done even when software clears it in the same cycle
      if (seg_end) begin
        done <= 1'b1;
      end else if (wr_stat & PWDATA[`KSM_ST_DONE]) begin
        done <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          // start is only honoured from idle
          BUSY <= start;
          if (start) begin
            state <= ST_RUN;
            act_slot <= c_slot;
            act_pair <= c_pair;
            act_prot <= c_prot;
            act_tail_ct <= cfg[`KSM_CFG_TAIL_CT];
            act_len <= next_len;
            act_limit <= next_limit;
            idx <= 12'h000;
            sub_off <= 7'h00;
            sub_base <= 12'h000;
            seg <= 1'b0;
          end
        end
        ST_RUN: begin
          // abort does not set done so software can tell a cut slot from a finished one
          if (abort | seg_end) begin
            state <= ST_IDLE;
            BUSY <= 1'b0;
            idx <= 12'h000;
            sub_off <= 7'h00;
            sub_base <= 12'h000;
            seg <= 1'b0;
          end else if (last) begin
            seg <= 1'b1;
            idx <= 12'h000;
            sub_off <= 7'h00;
            sub_base <= 12'h000;
          end else if (step) begin
            idx <= idx + 12'h001;
            // subfield position counts payload bits only
            if (!in_tail) begin
              if (sub_off == `KSM_SUB_LEN - 7'h01) begin
                sub_off <= 7'h00;
                sub_base <= sub_base + `KSM_SUB_LEN_W;
              end else begin
                sub_off <= sub_off + 7'h01;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          BUSY <= 1'b0;
          idx <= 12'h000;
          seg <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== tb/ksm_checker.sv ====
// port-level assertions for the key stream field mapper
`timescale 1ns/1ps
module ksm_checker (
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PREADY,
  input wire PSLVERR,
  input wire KS_VALID,
  input wire KS_BIT,
  input wire FLD_BIT,
  input wire OUT_VALID,
  input wire OUT_BIT,
  input wire OUT_ENC,
  input wire [11:0] OUT_INDEX,
  input wire SEG_DONE,
  input wire BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_step;
    BUSY && KS_VALID;
  endsequence
  sequence s_out_then_out;
    OUT_VALID && !SEG_DONE ##1 OUT_VALID;
  endsequence
  a_ready_wait: assert property ($rose(PENABLE) && PSEL |=> PREADY)
    else $error("ready missing after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  a_err_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside access phase");
  a_step_out: assert property (s_step |=> OUT_VALID) else $error("consumed bit gave no output");
  a_idle_quiet: assert property (!(BUSY && KS_VALID) |=> !OUT_VALID)
    else $error("output without a consumed bit");
  a_xor_map: assert property (s_step ##1 OUT_VALID |->
    OUT_BIT == ($past(FLD_BIT) ^ ($past(KS_BIT) & OUT_ENC))) else $error("output bit wrong");
  a_index_next: assert property (s_out_then_out |-> OUT_INDEX == $past(OUT_INDEX) + 12'h001)
    else $error("index did not advance by one");
  a_index_wrap: assert property (OUT_VALID && SEG_DONE ##1 OUT_VALID |-> OUT_INDEX == 12'h000)
    else $error("second segment did not start at zero");
  a_done_valid: assert property (SEG_DONE |-> OUT_VALID) else $error("segment end without bit");
endmodule

bind ksm_mapper ksm_checker ksm_checker_inst (.CLK, .RST, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .KS_VALID, .KS_BIT, .FLD_BIT, .OUT_VALID, .OUT_BIT, .OUT_ENC, .OUT_INDEX, .SEG_DONE, .BUSY);

// ==== tb/ksm_kgen.sv ====
// key stream generator and field source model
`timescale 1ns/1ps
module ksm_kgen (
  input wire clk,
  input wire rst,
  input wire busy,
  input wire slow,
  output reg ks_valid,
  output reg ks_bit,
  output reg fld_bit
);
  reg [15:0] lf;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      lf <= 16'hACE1;
      ks_valid <= 1'b0;
      ks_bit <= 1'b0;
      fld_bit <= 1'b0;
    end else begin
      lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      // bits offered in generator order while the mapper wants them
      ks_valid <= busy && !(slow && ks_valid);
      // lines change every cycle so a stale bit never looks held
      ks_bit <= lf[0];
      fld_bit <= lf[7];
    end
  end
endmodule

// ==== tb/ksm_mapper_tb_top.sv ====
// self-checking bench for the key stream field mapper
`timescale 1ns/1ps
`include "ksm_regs.vh"
module ksm_mapper_tb_top;
  logic CLK, RST, PSEL, PENABLE, PWRITE, slow, er, ct;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic PREADY, PSLVERR, KS_VALID, KS_BIT, FLD_BIT, OUT_VALID, OUT_BIT, OUT_ENC, SEG_DONE, BUSY;
  logic [11:0] OUT_INDEX;
  logic [1:0] e, pt;
  logic [1:0] q[$];
  int failures, n_compared, cyc, idx, L, D, nout;
  int lfull[4] = '{680, 1000, 744, 1128};
  int ldbl[4] = '{1640, 2440, 1704, 2568};
  int lhalf[4] = '{200, 280, 264, 408};
  int dfull[4] = '{608, 928, 672, 1056};
  int ddbl[4] = '{1568, 2368, 1632, 2496};
  int xtra[4] = '{0, 0, 64, 128};
  ksm_mapper ksm_mapper_inst (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .KS_VALID, .KS_BIT, .FLD_BIT, .OUT_VALID, .OUT_BIT, .OUT_ENC,
    .OUT_INDEX, .SEG_DONE, .BUSY);
  ksm_kgen ksm_kgen_inst (.clk(CLK), .rst(RST), .busy(BUSY), .slow(slow),
    .ks_valid(KS_VALID), .ks_bit(KS_BIT), .fld_bit(FLD_BIT));
  initial begin
    CLK = 0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask
  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    // no local limit: only the cycle ceiling ends a wait
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA; er = PSLVERR;
    PSEL <= 0; PENABLE <= 0;
  endtask
  function automatic logic mapped(int i);
    int o = i - 40;
    if (i < 40) return ct;
    if (pt == 0) return 1'b1;
    if (pt == 1) return o < D;
    // subfield check bits and the field tail stay clear
    if (pt == 2) return o % 80 < 64 && o / 80 * 80 + 120 <= L;
    return 1'b0;
  endfunction
  task automatic cfg(input int s, p, t, c, j);
    pt = 2'(t); ct = 1'(c);
    L = s == 0 ? lhalf[p] + (p % 2 ? 3 : 2) * j : s == 1 ? lfull[p] : ldbl[p];
    D = t == 0 ? L - 40 : s == 0 ? L - 72 : s == 1 ? dfull[p] : ddbl[p];
    apb(1, `KSM_OFS_CONFIG, {16'h0000, 8'(j), 1'b0, 1'(c), 2'(t), 2'(p), 2'(s)});
    apb(0, `KSM_OFS_LENGTH, 32'h0000_0000);
    chk(rd[11:0], L);
    if (t < 2) chk(rd[27:16], D);
    apb(0, `KSM_OFS_EXTRA, 32'h0000_0000);
    chk(rd[7:0], xtra[p]);
  endtask
  task automatic go(input logic w);
    slow <= w; idx = 0; nout = 0; q.delete();
    apb(1, `KSM_OFS_CTRL, 32'h0000_0001);
  endtask
  task automatic run(input int s, p, t, c, j, input logic w);
    cfg(s, p, t, c, j);
    go(w);
    @(posedge CLK);
    while (BUSY !== 1'b0) @(posedge CLK);
    repeat (2) @(posedge CLK);
    chk(nout, 2 * L);
    apb(0, `KSM_OFS_STATUS, 32'h0000_0000);
    chk(rd[1:0], 2'b10);
    apb(1, `KSM_OFS_STATUS, 32'h0000_0002);
    apb(0, `KSM_OFS_STATUS, 32'h0000_0000);
    chk(rd[1:0], 2'b00);
  endtask
  always @(posedge CLK) begin
    if (BUSY && KS_VALID) q.push_back({KS_BIT, FLD_BIT});
    if (OUT_VALID) begin
      e = q.pop_front();
      chk(OUT_INDEX, idx);
      chk(OUT_ENC, mapped(idx));
      chk(OUT_BIT, e[0] ^ (e[1] & mapped(idx)));
      chk(SEG_DONE, idx == L - 1);
      idx = idx == L - 1 ? 0 : idx + 1;
      nout++;
    end
  end
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      close_out;
    end
  end
  initial begin
    RST = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = 0; PWDATA = 0; slow = 0;
    repeat (10) @(posedge CLK);
    RST <= 0;
    apb(0, `KSM_OFS_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(0, 8'h14, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    apb(1, `KSM_OFS_CONFIG, 32'h0000_0017);
    apb(0, `KSM_OFS_LENGTH, 32'h0000_0000);
    chk(rd, 32'h03A0_03E8);
    for (int t = 0; t < 2; t++) begin
      for (int s = 0; s < 3; s++) for (int p = 0; p < 4; p++) cfg(s, p, t, 0, 5);
    end
    cfg(1, 0, 0, 1, 0);
    go(0);
    repeat (40) @(posedge CLK);
    apb(1, `KSM_OFS_CONFIG, 32'h0000_0002);
    apb(0, `KSM_OFS_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_0041);
    apb(1, `KSM_OFS_CTRL, 32'h0000_0002);
    repeat (3) @(posedge CLK);
    apb(0, `KSM_OFS_STATUS, 32'h0000_0000);
    chk(rd[1:0], 2'b00);
    run(1, 0, 0, 1, 0, 0);
    run(0, 2, 1, 0, 5, 1);
    run(1, 3, 2, 0, 0, 0);
    run(2, 1, 1, 1, 0, 0);
    run(0, 0, 3, 1, 0, 0);
    close_out;
  end
endmodule
